//--- rtl/accumulator_op_decoder.sv
// Accumulator group opcode decoder with cycle sequencing and result latch.
//
// What this block does
// - Register field picks register, memory or accumulator.
// - Conditional rows pick short or long count.
// - Subtract register/memory, optional borrow, 4/7 cycles.
// - Subtract immediate byte, optional borrow, 7 cycles.
// - Register logic/compare in 4 cycles, compare no accumulator write.
// - Memory logic or compare takes 7 cycles.
// - Immediate logic/compare 7 cycles, compare keeps accumulator.
// - Rotate left/right, circular or via carry, 4 cycles.
`default_nettype none
module accumulator_op_decoder
  import acc_dec_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    op_valid,
  output logic                         op_ready,
  input  wire logic [7:0]              opcode,
  input  wire logic [7:0]              imm_byte,
  input  wire logic [7:0]              reg_data,
  input  wire logic [7:0]              mem_data,
  input  wire logic [7:0]              acc_in,
  input  wire logic [acc_dec_pkg::FLAG_W-1:0] flags_in,
  output logic [2:0]                   reg_index,
  output acc_dec_pkg::src_t            src_sel,
  output logic [acc_dec_pkg::CYC_W-1:0] cycles,
  output logic                         cond_taken,
  output logic                         unsupported,
  output logic                         done,
  output logic [7:0]                   acc_out,
  output logic                         acc_we,
  output logic [acc_dec_pkg::FLAG_W-1:0] flags_out,
  output logic                         flags_we
);

  import acc_dec_pkg::*;

  // Maps a three-bit register field onto its operand source.
  function automatic src_t field_src(input logic [2:0] f);
    if (f == FIELD_MEM)
      return SRC_MEM;
    else if (f == FIELD_ACC)
      return SRC_ACC;
    else
      return SRC_REG;
  endfunction

  // Tests a condition code against the flags: NZ Z NC C PO PE P M.
  function automatic logic cond_met(input logic [2:0] ccc,
                                    input logic [FLAG_W-1:0] f);
    logic bit_v;
    bit_v = 1'b0;
    case (ccc[2:1])
      2'h0:    bit_v = f[FLAG_Z];
      2'h1:    bit_v = f[FLAG_C];
      2'h2:    bit_v = f[FLAG_P];
      default: bit_v = f[FLAG_S];
    endcase
    return ccc[0] ? bit_v : ~bit_v;
  endfunction

  // Even parity flag is set when the result has an even number of ones.
  function automatic logic parity_even(input logic [7:0] v);
    return ~(^v);
  endfunction

  state_t                state_r;
  state_t                state_nxt;
  logic [CYC_W-1:0]      count_r;
  logic [CYC_W-1:0]      cycles_r;
  alu_op_t               op_r;
  logic [7:0]            a_r;
  logic [7:0]            b_r;
  logic                  cin_r;
  logic [FLAG_W-1:0]     flags_r;
  logic [2:0]            reg_index_r;
  src_t                  src_r;
  logic                  taken_r;
  logic                  unsup_r;
  logic                  done_r;
  logic [7:0]            acc_out_r;
  logic                  acc_we_r;
  logic [FLAG_W-1:0]     flags_out_r;
  logic                  flags_we_r;

  alu_if alu_bus ();

  acc_alu u_alu (
    .bus (alu_bus)
  );

  // Field slices of the incoming opcode.
  wire logic [1:0] grp     = opcode[7:6];
  wire logic [2:0] mid     = opcode[5:3];
  wire logic [2:0] low     = opcode[2:0];
  wire logic       acc_grp = (mid >= OPF_SUB);

  // Row classification.
  wire logic is_reg_op = (grp == GRP_REG) && acc_grp;
  wire logic is_imm_op = (grp == GRP_IMM) && (low == LOW_IMM) && acc_grp;
  wire logic is_rot_op = (grp == GRP_ROT) && (low == LOW_ROT) && !mid[2];
  wire logic is_ret_cc = (grp == GRP_IMM) && (low == LOW_RET);
  wire logic is_cal_cc = (grp == GRP_IMM) && (low == LOW_CALL);
  wire logic cond_ok   = cond_met(mid, flags_in);

  // Source of the second operand.
  wire src_t dec_src = is_imm_op ? SRC_IMM : field_src(low);

  // Memory rows take longer than register rows.
  wire logic [CYC_W-1:0] reg_cycles =
    (dec_src == SRC_MEM) ? CYC_MEM : CYC_REG;

  // Cycle count per row; conditional rows depend on the flags.
  wire logic [CYC_W-1:0] dec_cycles =
    is_reg_op ? reg_cycles :
    is_imm_op ? CYC_IMM :
    is_rot_op ? CYC_ROT :
    is_ret_cc ? (cond_ok ? CYC_RET_LONG : CYC_RET_SHORT) :
    is_cal_cc ? (cond_ok ? CYC_CALL_LONG : CYC_CALL_SHORT) :
    CYC_UNSUP;

  // Operation code handed to the ALU.
  wire alu_op_t dec_op =
    (is_reg_op || is_imm_op) ?
      ((mid == OPF_SUB) ? ALU_SUB :
       (mid == OPF_SUBB) ? ALU_SUBB :
       (mid == OPF_AND) ? ALU_AND :
       (mid == OPF_XOR) ? ALU_XOR :
       (mid == OPF_OR)  ? ALU_OR  : ALU_COMP) :
    is_rot_op ?
      ((mid[1:0] == 2'h0) ? ALU_ROL :
       (mid[1:0] == 2'h1) ? ALU_ROR :
       (mid[1:0] == 2'h2) ? ALU_RCL : ALU_RCR) :
    ALU_NONE;

  // Operand selected by the decoded source.
  wire logic [7:0] dec_b =
    (dec_src == SRC_IMM) ? imm_byte :
    (dec_src == SRC_MEM) ? mem_data :
    (dec_src == SRC_ACC) ? acc_in : reg_data;

  wire logic accept  = op_valid && (state_r == ST_IDLE);
  wire logic latch_r = (state_r == ST_EXEC) && (count_r == CYC_LATCH);

  // The ALU sees operands captured at accept, so inputs may change after.
  assign alu_bus.op  = op_r;
  assign alu_bus.a   = a_r;
  assign alu_bus.b   = b_r;
  assign alu_bus.cin = cin_r;

  // Zero, sign and parity follow the ALU value; carry comes from the ALU.
  wire logic [FLAG_W-1:0] new_flags = {alu_bus.result[7],
                                       (alu_bus.result == 8'h00),
                                       parity_even(alu_bus.result),
                                       alu_bus.cout};
  wire logic [7:0] compare_diff = a_r - b_r;
  wire logic [FLAG_W-1:0] compare_flags = {compare_diff[7],
                                           (compare_diff == 8'h00),
                                           parity_even(compare_diff),
                                           alu_bus.cout};
  wire logic is_compare = (op_r == ALU_COMP);
  wire logic is_rot = (op_r >= ALU_ROL) && (op_r <= ALU_RCR);
  // Rotates change only the carry bit of the flag vector.
  wire logic [FLAG_W-1:0] res_flags =
    is_compare ? compare_flags :
    is_rot ? {flags_r[FLAG_W-1:1], alu_bus.cout} : new_flags;

  // Sequencer: idle, count out the instruction, one done cycle.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: state_nxt = accept ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_nxt = latch_r ? ST_DONE : ST_EXEC;
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State and countdown.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      count_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (accept)
        count_r <= dec_cycles - 5'h01;
      else if (state_r == ST_EXEC)
        count_r <= count_r - 5'h01;
    end
  end

  // Capture of the decoded instruction at accept.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      op_r        <= ALU_NONE;
      a_r         <= 8'h00;
      b_r         <= 8'h00;
      cin_r       <= 1'b0;
      flags_r     <= '0;
      cycles_r    <= '0;
      reg_index_r <= 3'h0;
      src_r       <= SRC_REG;
      taken_r     <= 1'b0;
      unsup_r     <= 1'b0;
    end
    else if (accept)
    begin
      op_r        <= dec_op;
      a_r         <= acc_in;
      b_r         <= dec_b;
      cin_r       <= flags_in[FLAG_C];
      flags_r     <= flags_in;
      cycles_r    <= dec_cycles;
      reg_index_r <= low;
      src_r       <= dec_src;
      taken_r     <= (is_ret_cc || is_cal_cc) && cond_ok;
      unsup_r     <= (dec_op == ALU_NONE) && !is_ret_cc && !is_cal_cc;
    end
  end

  // Results land in the last cycle of the instruction as a one-cycle pulse.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      done_r      <= 1'b0;
      acc_out_r   <= 8'h00;
      acc_we_r    <= 1'b0;
      flags_out_r <= '0;
      flags_we_r  <= 1'b0;
    end
    else
    begin
      done_r     <= latch_r;
      acc_we_r   <= latch_r && alu_bus.acc_we;
      flags_we_r <= latch_r && alu_bus.carry_we;
      if (latch_r)
      begin
        acc_out_r   <= alu_bus.acc_we ? alu_bus.result : a_r;
        flags_out_r <= res_flags;
      end
    end
  end

  assign op_ready    = (state_r == ST_IDLE);
  assign reg_index   = reg_index_r;
  assign src_sel     = src_r;
  assign cycles      = cycles_r;
  assign cond_taken  = taken_r;
  assign unsupported = unsup_r;
  assign done        = done_r;
  assign acc_out     = acc_out_r;
  assign acc_we      = acc_we_r;
  assign flags_out   = flags_out_r;
  assign flags_we    = flags_we_r;

endmodule // accumulator_op_decoder
`default_nettype wire

//--- rtl/acc_dec_pkg.sv
// Constants and types shared by the accumulator group decoder and its ALU.
`default_nettype none
package acc_dec_pkg;

  // Width of a cycle count.
  localparam int CYC_W = 5;

  // Clock cycles per instruction class.
  localparam logic [4:0] CYC_REG        = 5'h04;
  localparam logic [4:0] CYC_MEM        = 5'h07;
  localparam logic [4:0] CYC_IMM        = 5'h07;
  localparam logic [4:0] CYC_ROT        = 5'h04;
  localparam logic [4:0] CYC_RET_SHORT  = 5'h05;
  localparam logic [4:0] CYC_RET_LONG   = 5'h0b;
  localparam logic [4:0] CYC_CALL_SHORT = 5'h0b;
  localparam logic [4:0] CYC_CALL_LONG  = 5'h11;
  localparam logic [4:0] CYC_UNSUP      = 5'h04;
  // Count at which the last-cycle result is latched.
  localparam logic [4:0] CYC_LATCH      = 5'h02;

  // Register field codes.
  localparam logic [2:0] FIELD_MEM = 3'h6;
  localparam logic [2:0] FIELD_ACC = 3'h7;

  // Opcode group prefixes in bits 7:6.
  localparam logic [1:0] GRP_ROT = 2'h0;
  localparam logic [1:0] GRP_REG = 2'h2;
  localparam logic [1:0] GRP_IMM = 2'h3;
  // Low three bits that mark the immediate, rotate and conditional rows.
  localparam logic [2:0] LOW_IMM  = 3'h6;
  localparam logic [2:0] LOW_ROT  = 3'h7;
  localparam logic [2:0] LOW_RET  = 3'h0;
  localparam logic [2:0] LOW_CALL = 3'h4;

  // Flag bit positions in the flag vector.
  localparam int FLAG_C = 0;
  localparam int FLAG_P = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_S = 3;
  localparam int FLAG_W = 4;

  // Operation codes in bits 5:3 of the accumulator group.
  localparam logic [2:0] OPF_SUB  = 3'h2;
  localparam logic [2:0] OPF_SUBB = 3'h3;
  localparam logic [2:0] OPF_AND  = 3'h4;
  localparam logic [2:0] OPF_XOR  = 3'h5;
  localparam logic [2:0] OPF_OR   = 3'h6;
  localparam logic [2:0] OPF_COMP = 3'h7;

  typedef enum logic [3:0] {
    ALU_NONE = 4'h0,
    ALU_SUB  = 4'h1,
    ALU_SUBB = 4'h2,
    ALU_AND  = 4'h3,
    ALU_XOR  = 4'h4,
    ALU_OR   = 4'h5,
    ALU_COMP = 4'h6,
    ALU_ROL  = 4'h7,
    ALU_ROR  = 4'h8,
    ALU_RCL  = 4'h9,
    ALU_RCR  = 4'ha
  } alu_op_t;

  typedef enum logic [1:0] {
    SRC_REG = 2'h0,
    SRC_MEM = 2'h1,
    SRC_ACC = 2'h2,
    SRC_IMM = 2'h3
  } src_t;

  // Gray coded along idle, execute, done.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b11
  } state_t;

endpackage
`default_nettype wire

//--- rtl/alu_if.sv
// Operand and result bundle between the decoder and its ALU.
`default_nettype none
interface alu_if;
  import acc_dec_pkg::*;
  alu_op_t    op;
  logic [7:0] a;
  logic [7:0] b;
  logic       cin;
  logic [7:0] result;
  logic       cout;
  logic       acc_we;
  logic       carry_we;
  modport ctrl (output op, output a, output b, output cin,
                input result, input cout, input acc_we, input carry_we);
  modport alu  (input op, input a, input b, input cin,
                output result, output cout, output acc_we,
                output carry_we);
endinterface
`default_nettype wire

//--- rtl/acc_alu.sv
// Combinational accumulator ALU for subtract, logic and rotate operations.
`default_nettype none
module acc_alu
  import acc_dec_pkg::*;
(
  alu_if.alu bus
);

  logic [8:0] diff;
  logic       borrow_in;

  // The borrow input is the carry flag only for the with-borrow form.
  assign borrow_in = (bus.op == ALU_SUBB) ? bus.cin : 1'b0;
  assign diff = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, borrow_in};

  // Result, carry and write enables per operation.
  always_comb
  begin
    bus.result   = bus.a;
    bus.cout     = bus.cin;
    bus.acc_we   = 1'b0;
    bus.carry_we = 1'b0;
    case (bus.op)
      ALU_SUB, ALU_SUBB:
      begin
        bus.result   = diff[7:0];
        bus.cout     = diff[8];
        bus.acc_we   = 1'b1;
        bus.carry_we = 1'b1;
      end
      ALU_COMP:
      begin
        bus.cout     = diff[8];
        bus.carry_we = 1'b1;
      end
      ALU_AND, ALU_XOR, ALU_OR:
      begin
        bus.result   = (bus.op == ALU_AND) ? (bus.a & bus.b) :
                       (bus.op == ALU_XOR) ? (bus.a ^ bus.b) :
                       (bus.a | bus.b);
        bus.cout     = 1'b0; // Logic operations clear the carry.
        bus.acc_we   = 1'b1;
        bus.carry_we = 1'b1;
      end
      ALU_ROL, ALU_ROR, ALU_RCL, ALU_RCR:
      begin
        bus.result   = (bus.op == ALU_ROL) ? {bus.a[6:0], bus.a[7]} :
                       (bus.op == ALU_ROR) ? {bus.a[0], bus.a[7:1]} :
                       (bus.op == ALU_RCL) ? {bus.a[6:0], bus.cin} :
                       {bus.cin, bus.a[7:1]};
        bus.cout     = (bus.op == ALU_ROL || bus.op == ALU_RCL) ?
                       bus.a[7] : bus.a[0];
        bus.acc_we   = 1'b1;
        bus.carry_we = 1'b1;
      end
      default:
      begin
        bus.result = bus.a;
      end
    endcase
  end

endmodule // acc_alu
`default_nettype wire

//--- bench/op_decoder_monitor.sv
// Port-level assertions for the accumulator group decoder.
`default_nettype none
module op_decoder_monitor
  import acc_dec_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       op_valid,
  input wire logic       op_ready,
  input wire logic [7:0] opcode,
  input wire logic [7:0] imm_byte,
  input wire logic [7:0] acc_in,
  input wire logic [3:0] flags_in,
  input wire logic [2:0] reg_index,
  input wire src_t       src_sel,
  input wire logic [4:0] cycles,
  input wire logic       cond_taken,
  input wire logic       done,
  input wire logic [7:0] acc_out,
  input wire logic       acc_we,
  input wire logic [3:0] flags_out,
  input wire logic       flags_we
);
  timeunit 1ns;
  timeprecision 1ps;

  // Request taken, and the two operand row shapes of the group.
  wire take = op_valid && op_ready;
  wire alu = opcode[7:6] == GRP_REG && opcode[5:4] != 2'h0;
  wire imm = opcode[7:6] == GRP_IMM && opcode[2:0] == LOW_IMM
    && opcode[5:4] != 2'h0;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_reg_four: assert property (
    take && alu && opcode[2:0] != FIELD_MEM
    |-> !done [*3] ##1 done && cycles == 5'h04)
    else $error("register op length wrong");
  a_mem_seven: assert property (
    take && alu && opcode[2:0] == FIELD_MEM |-> ##6 done && cycles == 5'h07)
    else $error("memory op length wrong");
  a_imm_seven: assert property (
    take && imm |-> ##1 !done [*5] ##1 done)
    else $error("immediate op length wrong");
  a_rot_writes: assert property (
    take && opcode[7:5] == 3'h0 && opcode[2:0] == LOW_ROT
    |-> ##3 done && acc_we && flags_we)
    else $error("rotate write wrong");
  a_compare_keeps: assert property (
    take && opcode == 8'hfe
    |-> ##6 !acc_we && flags_we && acc_out == $past(acc_in, 6))
    else $error("compare changed accumulator");
  a_src_field: assert property (
    take && alu |=> reg_index == $past(opcode[2:0]) && src_sel ==
    ($past(opcode[2:0]) == FIELD_MEM ? SRC_MEM
    : $past(opcode[2:0]) == FIELD_ACC ? SRC_ACC : SRC_REG))
    else $error("operand source wrong");
  a_ret_count: assert property (
    take && opcode[7:6] == GRP_IMM && opcode[2:0] == LOW_RET
    |=> cycles == (cond_taken ? 5'h0b : 5'h05))
    else $error("return count wrong");
  a_imm_borrow: assert property (
    take && opcode == 8'hde |-> ##6 {flags_out[0], acc_out} ==
    {1'b0, $past(acc_in, 6)} - {1'b0, $past(imm_byte, 6)}
    - {8'h00, $past(flags_in[0], 6)})
    else $error("borrow subtract wrong");

  // Main scenarios seen at least once.
  c_compare: cover property (take && opcode == 8'hfe);
  c_taken: cover property (done && cond_taken);
  c_b2b: cover property (done ##1 take);
endmodule // op_decoder_monitor

bind accumulator_op_decoder op_decoder_monitor u_mon (
  .clk(clk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready),
  .opcode(opcode), .imm_byte(imm_byte), .acc_in(acc_in),
  .flags_in(flags_in), .reg_index(reg_index), .src_sel(src_sel),
  .cycles(cycles), .cond_taken(cond_taken), .done(done),
  .acc_out(acc_out), .acc_we(acc_we), .flags_out(flags_out),
  .flags_we(flags_we));
`default_nettype wire

//--- bench/fetch_model.sv
// Fetch and datapath stand-in that offers opcodes and operands.
`default_nettype none
module fetch_model (
  input  wire logic       clk,
  input  wire logic       op_ready,
  output var  logic       op_valid,
  output var  logic [7:0] opcode,
  output var  logic [7:0] imm_byte,
  output var  logic [7:0] reg_data,
  output var  logic [7:0] mem_data,
  output var  logic [7:0] acc_in,
  output var  logic [3:0] flags_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Nothing is offered until the bench asks for a transfer.
  initial
  begin
    op_valid = 1'b0;
    {opcode, imm_byte, reg_data, mem_data, acc_in, flags_in} = '0;
  end

  // Called just after an edge; all lines hold until the taking edge.
  task automatic issue(logic [7:0] op, im, r, m, a, logic [3:0] f);
    op_valid = 1'b1;
    {opcode, imm_byte, reg_data, mem_data, acc_in, flags_in} =
      {op, im, r, m, a, f};
    for (int i = 0; i < 40 && op_ready !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
  endtask

  // Released lines show the inverse, so stale operands cannot pass.
  task automatic idle();
    op_valid = 1'b0;
    {opcode, imm_byte, reg_data, mem_data, acc_in, flags_in} =
      ~{opcode, imm_byte, reg_data, mem_data, acc_in, flags_in};
  endtask
endmodule // fetch_model
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the accumulator group decoder.
`default_nettype none
module tb import acc_dec_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [4:0] n;
    logic [7:0] acc;
    logic [3:0] fl;
    logic [2:0] ri;
    src_t       src;
    logic       aw, fw, uns, cnd, ck_acc, ck_src;
  } exp_t;
  logic        clk, rst, op_valid, op_ready, cond_taken, unsupported;
  logic        done, acc_we, flags_we;
  logic [7:0]  opcode, imm_byte, reg_data, mem_data, acc_in, acc_out;
  logic [3:0]  flags_in, flags_out;
  logic [2:0]  reg_index;
  logic [4:0]  cycles;
  src_t        src_sel;
  logic [15:0] seed = 16'h4ce9;
  exp_t        expq[$];
  exp_t        nt;
  int          since, failures, check_count;

  accumulator_op_decoder u_dut (
    .clk(clk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready),
    .opcode(opcode), .imm_byte(imm_byte), .reg_data(reg_data),
    .mem_data(mem_data), .acc_in(acc_in), .flags_in(flags_in),
    .reg_index(reg_index), .src_sel(src_sel), .cycles(cycles),
    .cond_taken(cond_taken), .unsupported(unsupported), .done(done),
    .acc_out(acc_out), .acc_we(acc_we), .flags_out(flags_out),
    .flags_we(flags_we));
  fetch_model u_fetch (
    .clk(clk), .op_ready(op_ready), .op_valid(op_valid),
    .opcode(opcode), .imm_byte(imm_byte), .reg_data(reg_data),
    .mem_data(mem_data), .acc_in(acc_in), .flags_in(flags_in));

  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Flags are {S,Z,P,C}; compare keeps A but sets flags from A-B.
  function automatic exp_t ref_op(logic [7:0] op, im, a, r, m,
                                  logic [3:0] f);
    exp_t       e;
    logic [7:0] b, res;
    logic [8:0] d;
    logic       hit;
    e = '0;
    e.n = 5'h04;
    e.acc = a;
    e.fl = f;
    e.ri = op[2:0];
    e.ck_acc = 1'b1;
    b = op[7:6] == GRP_IMM ? im : op[2:0] == FIELD_MEM ? m
      : op[2:0] == FIELD_ACC ? a : r;
    e.src = op[7:6] == GRP_IMM ? SRC_IMM : op[2:0] == FIELD_MEM ? SRC_MEM
      : op[2:0] == FIELD_ACC ? SRC_ACC : SRC_REG;
    d = {1'b0, a} - {1'b0, b} - {8'h00, f[0] && op[5:3] == OPF_SUBB};
    res = op[5:3] == OPF_AND ? a & b : op[5:3] == OPF_XOR ? a ^ b
      : op[5:3] == OPF_OR ? a | b : d[7:0];
    hit = op[5:4] == 2'h0 ? f[2] : op[5:4] == 2'h1 ? f[0]
      : op[5:4] == 2'h2 ? f[1] : f[3];
    hit = hit == op[3];
    if (op[7:6] == GRP_ROT)
    begin
      e.aw = 1'b1;
      e.fw = 1'b1;
      {e.fl[0], e.acc} = op[4:3] == 2'h0 ? {a, a[7]}
        : op[4:3] == 2'h1 ? {a[0], a[0], a[7:1]}
        : op[4:3] == 2'h2 ? {a, f[0]} : {a[0], f[0], a[7:1]};
    end
    else if (op[7:6] == GRP_IMM && op[2:0] != LOW_IMM)
    begin
      e.cnd = hit;
      e.ck_acc = 1'b0;
      e.n = op[2] ? (hit ? 5'h11 : 5'h0b) : (hit ? 5'h0b : 5'h05);
    end
    else if (op[5:4] == 2'h0)
      e.uns = 1'b1;
    else
    begin
      e.ck_src = 1'b1;
      e.aw = op[5:3] != OPF_COMP;
      e.fw = 1'b1;
      e.acc = e.aw ? res : a;
      e.fl = {res[7], res == 8'h00, ~^res, op[5] && e.aw ? 1'b0 : d[8]};
      e.n = op[7] && op[6] || op[2:0] == FIELD_MEM ? 5'h07 : 5'h04;
    end
    return e;
  endfunction

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Random operands; the expectation is noted before the request goes.
  task automatic send(logic [7:0] op);
    logic [7:0] a, im, r, m;
    seed = lfsr(seed);
    {a, im} = seed;
    seed = lfsr(seed);
    {r, m} = seed;
    seed = lfsr(seed);
    expq.push_back(ref_op(op, im, a, r, m, seed[3:0]));
    u_fetch.issue(op, im, r, m, a, seed[3:0]);
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Free-running clock.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard, well past the several hundred cycles the run needs.
  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  // Each completion is matched against the oldest outstanding note.
  always @(posedge clk)
  begin
    since = op_valid && op_ready ? 0 : since + 1;
    if (!rst && done === 1'b1)
    begin
      chk("queue", 16'h1, 16'(expq.size() != 0));
      nt = expq.pop_front();
      chk("latency", 16'(nt.n - 5'h01), 16'(since));
      chk("cycles", 16'(nt.n), 16'(cycles));
      chk("writes", 16'({nt.aw, nt.fw, nt.uns}),
        16'({acc_we, flags_we, unsupported}));
      if (nt.ck_acc)
        chk("acc", 16'(nt.acc), 16'(acc_out));
      if (nt.fw)
        chk("flags", 16'(nt.fl), 16'(flags_out));
      if (!nt.ck_acc)
        chk("cond", 16'(nt.cnd), 16'(cond_taken));
      if (nt.ck_src)
        chk("source", 16'({nt.src, nt.ri}),
          16'({src_sel, reg_index}));
    end
  end

  // Reset, every opcode family, then a reset in mid-instruction.
  initial
  begin
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 48; i++) send({2'h2, 6'(i + 16)});
    for (int i = 2; i < 8; i++) send({2'h3, 3'(i), 3'h6});
    for (int i = 0; i < 4; i++) send({3'h0, 2'(i), 3'h7});
    for (int i = 0; i < 32; i++)
    begin
      send({2'h3, 3'(i), i[3] ? 3'h4 : 3'h0});
      if (i[0])
      begin
        u_fetch.idle();
        @(posedge clk);
        #1;
      end
    end
    send(8'h80);
    send(8'h8f);
    send(8'h97);
    u_fetch.idle();
    rst = 1'b1;
    expq.delete();
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk("reset", 16'h0100, 16'({op_ready, done, acc_we, flags_we, cycles}));
    send(8'h9e);
    u_fetch.idle();
    for (int i = 0; i < 40 && expq.size() != 0; i++) @(posedge clk);
    chk("left", 16'h0, 16'(expq.size()));
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
